// ==== common/bphc_pkg.sv ====
package bphc_pkg;

    // ==========================================================
    // Clock
    // ==========================================================
    localparam int CLK_PERIOD_NS = 5;

    // ==========================================================
    // Three-level strap encoding
    // ==========================================================
    typedef enum logic [1:0] {
        TRI_LOW  = 2'h0,
        TRI_HIGH = 2'h1,
        TRI_OPEN = 2'h2
    } bphc_tri_type;

    // ==========================================================
    // Switching frequency
    // ==========================================================
    localparam logic [1:0] SWITCHING_RATE_SELECT_CODE_400 = 2'h0;
    localparam logic [1:0] SWITCHING_RATE_SELECT_CODE_565 = 2'h1;
    localparam logic [1:0] SWITCHING_RATE_SELECT_CODE_790 = 2'h2;
    localparam int SWITCHING_RATE_SELECT_400_KHZ = 400;
    localparam int SWITCHING_RATE_SELECT_565_KHZ = 565;
    localparam int SWITCHING_RATE_SELECT_790_KHZ = 790;
    localparam int PERIOD_W     = 10;
    localparam logic [PERIOD_W-1:0] PERIOD_400 =
        PERIOD_W'(1_000_000 / (SWITCHING_RATE_SELECT_400_KHZ * CLK_PERIOD_NS));
    localparam logic [PERIOD_W-1:0] PERIOD_565 =
        PERIOD_W'(1_000_000 / (SWITCHING_RATE_SELECT_565_KHZ * CLK_PERIOD_NS));
    localparam logic [PERIOD_W-1:0] PERIOD_790 =
        PERIOD_W'(1_000_000 / (SWITCHING_RATE_SELECT_790_KHZ * CLK_PERIOD_NS));

    // ==========================================================
    // Valley current limit level
    // ==========================================================
    localparam logic [1:0] VALLEY_LIMIT_SELECT_CODE_4A6 = 2'h0;
    localparam logic [1:0] VALLEY_LIMIT_SELECT_CODE_6A2 = 2'h1;
    localparam logic [1:0] VALLEY_LIMIT_SELECT_CODE_6A8 = 2'h2;

    // ==========================================================
    // Output voltage setpoints, reference in millivolts
    // ==========================================================
    localparam int REF_W = 12;
    localparam logic [3:0] VOUT_CODE_3V3 = 4'h0;
    localparam logic [3:0] VOUT_CODE_2V5 = 4'h1;
    localparam logic [3:0] VOUT_CODE_1V8 = 4'h2;
    localparam logic [3:0] VOUT_CODE_1V5 = 4'h3;
    localparam logic [3:0] VOUT_CODE_1V2 = 4'h4;
    localparam logic [3:0] VOUT_CODE_1V0 = 4'h5;
    localparam logic [3:0] VOUT_CODE_0V9 = 4'h6;
    localparam logic [3:0] VOUT_CODE_0V8 = 4'h7;
    localparam logic [3:0] VOUT_CODE_0V7 = 4'h8;
    localparam logic [REF_W-1:0] VOUT_MV_3V3 = 12'hce4;
    localparam logic [REF_W-1:0] VOUT_MV_2V5 = 12'h9c4;
    localparam logic [REF_W-1:0] VOUT_MV_1V8 = 12'h708;
    localparam logic [REF_W-1:0] VOUT_MV_1V5 = 12'h5dc;
    localparam logic [REF_W-1:0] VOUT_MV_1V2 = 12'h4b0;
    localparam logic [REF_W-1:0] VOUT_MV_1V0 = 12'h3e8;
    localparam logic [REF_W-1:0] VOUT_MV_0V9 = 12'h384;
    localparam logic [REF_W-1:0] VOUT_MV_0V8 = 12'h320;
    localparam logic [REF_W-1:0] VOUT_MV_0V7 = 12'h2bc;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int BLANK_NS = 108;
    localparam int BLANK_W  = 5;
    localparam logic [BLANK_W-1:0] BLANK_CYCLES =
        BLANK_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SS_RATE_UV_PER_MS = 450000;
    localparam int REF_LSB_UV        = 1000;
    localparam int SS_STEP_CYCLES_DEFAULT =
        (REF_LSB_UV * 1_000_000) / (SS_RATE_UV_PER_MS * CLK_PERIOD_NS);
    localparam int STEP_W            = 16;
    localparam int HICCUP_SS_MULT    = 3;
    localparam int WAIT_W            = 14;

    // ==========================================================
    // Fault counter
    // ==========================================================
    localparam logic [3:0] FAULT_MIN = 4'h0;
    localparam logic [3:0] FAULT_MAX = 4'hf;

    // ==========================================================
    // Sequencer states, Gray along the start-up path
    // ==========================================================
    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_LATCH   = 3'h1,
        ST_SOFT    = 3'h3,
        ST_RUN     = 3'h2,
        ST_HICCUP  = 3'h6,
        ST_THERMAL = 3'h7
    } bphc_state_type;

endpackage

// ==== hdl/bphc_sync.sv ====
`timescale 1ns/1ps
module bphc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ==== hdl/bphc_top.sv ====
`timescale 1ns/1ps
module bphc_top
    import bphc_pkg::*;
#(
    parameter int SS_STEP_CYCLES = SS_STEP_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Strap comparators: pin above high level, pin below low level
    input  wire logic             switching_rate_select_above,
    input  wire logic             switching_rate_select_below,
    input  wire logic             vout_code_low_above,
    input  wire logic             vout_code_low_below,
    input  wire logic             vout_code_high_above,
    input  wire logic             vout_code_high_below,
    input  wire logic             valley_limit_select_above,
    input  wire logic             valley_limit_select_below,
    // Enable comparators
    input  wire logic             enable_delay_input_supply,
    input  wire logic             enable_delay_input_deliver,
    // Analog flags
    input  wire logic             valley_limit_flag,
    input  wire logic             high_side_limit_flag,
    input  wire logic             over_temp_flag,
    input  wire logic             modulator_on_request,
    input  wire logic             reverse_current_flag,
    // Power stage
    output logic                  high_side_on_q,
    output logic                  low_side_on_q,
    output logic                  stage_tristate_q,
    output logic                  ldo_enable_q,
    // Reference and decoded settings
    output logic      [REF_W-1:0] reference_mv_q,
    output logic      [1:0]       switching_rate_code_q,
    output logic      [3:0]       vout_setpoint_code_q,
    output logic      [1:0]       valley_limit_code_q,
    // Status
    output logic      [3:0]       fault_count_q,
    output logic                  soft_start_active_q,
    output logic                  hiccup_active_q,
    output logic                  thermal_shutdown_q
);

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic bphc_tri_type tri_decode(input logic above,
                                                input logic below);
        if (above) begin
            return TRI_HIGH;
        end else if (below) begin
            return TRI_LOW;
        end else begin
            return TRI_OPEN;
        end
    endfunction

    function automatic logic [3:0] vout_decode(input bphc_tri_type hi,
                                               input bphc_tri_type lo);
        logic [3:0] code;
        code = VOUT_CODE_0V7;
        case ({hi, lo})
            {TRI_LOW,  TRI_LOW}:  code = VOUT_CODE_3V3;
            {TRI_LOW,  TRI_HIGH}: code = VOUT_CODE_2V5;
            {TRI_HIGH, TRI_LOW}:  code = VOUT_CODE_1V8;
            {TRI_HIGH, TRI_HIGH}: code = VOUT_CODE_1V5;
            {TRI_LOW,  TRI_OPEN}: code = VOUT_CODE_1V2;
            {TRI_OPEN, TRI_LOW}:  code = VOUT_CODE_1V0;
            {TRI_HIGH, TRI_OPEN}: code = VOUT_CODE_0V9;
            {TRI_OPEN, TRI_HIGH}: code = VOUT_CODE_0V8;
            default:              code = VOUT_CODE_0V7;
        endcase
        return code;
    endfunction

    function automatic logic [REF_W-1:0] vout_mv(input logic [3:0] code);
        logic [REF_W-1:0] mv;
        mv = VOUT_MV_0V7;
        case (code)
            VOUT_CODE_3V3: mv = VOUT_MV_3V3;
            VOUT_CODE_2V5: mv = VOUT_MV_2V5;
            VOUT_CODE_1V8: mv = VOUT_MV_1V8;
            VOUT_CODE_1V5: mv = VOUT_MV_1V5;
            VOUT_CODE_1V2: mv = VOUT_MV_1V2;
            VOUT_CODE_1V0: mv = VOUT_MV_1V0;
            VOUT_CODE_0V9: mv = VOUT_MV_0V9;
            VOUT_CODE_0V8: mv = VOUT_MV_0V8;
            default:       mv = VOUT_MV_0V7;
        endcase
        return mv;
    endfunction

    function automatic logic [PERIOD_W-1:0] period_of(
        input logic [1:0] code);
        logic [PERIOD_W-1:0] p;
        p = PERIOD_400;
        case (code)
            SWITCHING_RATE_SELECT_CODE_565: p = PERIOD_565;
            SWITCHING_RATE_SELECT_CODE_790: p = PERIOD_790;
            default:       p = PERIOD_400;
        endcase
        return p;
    endfunction

    // ==========================================================
    // Input synchronisation
    // ==========================================================
    localparam int SYNC_W = 15;

    logic [SYNC_W-1:0] sync_vec;
    logic              s_switching_rate_select_above;
    logic              s_switching_rate_select_below;
    logic              s_vlo_above;
    logic              s_vlo_below;
    logic              s_vhi_above;
    logic              s_vhi_below;
    logic              s_valley_limit_select_above;
    logic              s_valley_limit_select_below;
    logic              s_en_supply;
    logic              s_en_deliver;
    logic              s_valley;
    logic              s_hs_limit;
    logic              s_hot;
    logic              s_on_req;
    logic              s_reverse;

    bphc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in ({switching_rate_select_above,
                    switching_rate_select_below,
                    vout_code_low_above, vout_code_low_below,
                    vout_code_high_above, vout_code_high_below,
                    valley_limit_select_above,
                    valley_limit_select_below,
                    enable_delay_input_supply,
                    enable_delay_input_deliver,
                    valley_limit_flag, high_side_limit_flag,
                    over_temp_flag, modulator_on_request,
                    reverse_current_flag}),
        .sync_out (sync_vec)
    );

    assign {s_switching_rate_select_above, s_switching_rate_select_below, s_vlo_above, s_vlo_below,
            s_vhi_above, s_vhi_below, s_valley_limit_select_above, s_valley_limit_select_below,
            s_en_supply, s_en_deliver, s_valley, s_hs_limit,
            s_hot, s_on_req, s_reverse} = sync_vec;

    // ==========================================================
    // Sequencer
    // ==========================================================
    bphc_state_type      state_q;
    logic [REF_W-1:0]    target_mv;
    logic [WAIT_W-1:0]   wait_cnt_q;
    logic [WAIT_W-1:0]   wait_limit;
    logic [STEP_W-1:0]   step_cnt_q;
    logic                step_tick;
    logic                deliver_ok;
    logic                switching;
    logic [PERIOD_W-1:0] cyc_cnt_q;
    logic                cyc_tick;
    logic                valley_seen_q;
    logic                hs_done_q;
    logic [BLANK_W-1:0]  blank_cnt_q;
    logic                ls_block_q;
    logic                hs_on_d;

    assign target_mv  = vout_mv(vout_setpoint_code_q);
    assign wait_limit = WAIT_W'(target_mv) * WAIT_W'(HICCUP_SS_MULT);
    assign step_tick  = (step_cnt_q == STEP_W'(SS_STEP_CYCLES - 1));
    assign deliver_ok = s_en_supply && s_en_deliver;
    assign switching  = (state_q == ST_SOFT) || (state_q == ST_RUN);
    assign cyc_tick   = switching &&
                        (cyc_cnt_q == period_of(switching_rate_code_q)
                                      - PERIOD_W'(1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
        end else if (!deliver_ok && state_q != ST_OFF) begin
            state_q <= ST_OFF;
        end else if (s_hot && state_q != ST_OFF) begin
            state_q <= ST_THERMAL;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (deliver_ok) begin
                        state_q <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    state_q <= ST_SOFT;
                end
                ST_SOFT: begin
                    if (fault_count_q == FAULT_MAX) begin
                        state_q <= ST_HICCUP;
                    end else if (reference_mv_q >= target_mv) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (fault_count_q == FAULT_MAX) begin
                        state_q <= ST_HICCUP;
                    end
                end
                ST_HICCUP: begin
                    if (step_tick && wait_cnt_q >= wait_limit) begin
                        state_q <= ST_SOFT;
                    end
                end
                ST_THERMAL: begin
                    state_q <= ST_SOFT;
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Strap capture happens only in the single latch cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            switching_rate_code_q <= SWITCHING_RATE_SELECT_CODE_400;
            vout_setpoint_code_q  <= VOUT_CODE_0V7;
            valley_limit_code_q   <= VALLEY_LIMIT_SELECT_CODE_6A8;
        end else if (state_q == ST_LATCH) begin
            case (tri_decode(s_switching_rate_select_above, s_switching_rate_select_below))
                TRI_LOW:  switching_rate_code_q <= SWITCHING_RATE_SELECT_CODE_565;
                TRI_HIGH: switching_rate_code_q <= SWITCHING_RATE_SELECT_CODE_790;
                default:  switching_rate_code_q <= SWITCHING_RATE_SELECT_CODE_400;
            endcase
            vout_setpoint_code_q <=
                vout_decode(tri_decode(s_vhi_above, s_vhi_below),
                            tri_decode(s_vlo_above, s_vlo_below));
            case (tri_decode(s_valley_limit_select_above, s_valley_limit_select_below))
                TRI_LOW:  valley_limit_code_q <= VALLEY_LIMIT_SELECT_CODE_4A6;
                TRI_HIGH: valley_limit_code_q <= VALLEY_LIMIT_SELECT_CODE_6A2;
                default:  valley_limit_code_q <= VALLEY_LIMIT_SELECT_CODE_6A8;
            endcase
        end
    end

    // ==========================================================
    // Soft-start ramp and hiccup wait
    // ==========================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_q <= '0;
        end else if (state_q != ST_SOFT && state_q != ST_HICCUP) begin
            step_cnt_q <= '0;
        end else if (step_tick) begin
            step_cnt_q <= '0;
        end else begin
            step_cnt_q <= step_cnt_q + STEP_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reference_mv_q <= '0;
        end else if (state_q == ST_SOFT) begin
            if (step_tick && reference_mv_q < target_mv) begin
                reference_mv_q <= reference_mv_q + REF_W'(1);
            end
        end else if (state_q != ST_RUN) begin
            reference_mv_q <= '0;
        end
    end

    // One wait step per reference step, three full ramps in all
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt_q <= '0;
        end else if (state_q != ST_HICCUP) begin
            wait_cnt_q <= '0;
        end else if (step_tick && wait_cnt_q < wait_limit) begin
            wait_cnt_q <= wait_cnt_q + WAIT_W'(1);
        end
    end

    // ==========================================================
    // Switching cycle and fault counter
    // ==========================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt_q <= '0;
        end else if (!switching || cyc_tick) begin
            cyc_cnt_q <= '0;
        end else begin
            cyc_cnt_q <= cyc_cnt_q + PERIOD_W'(1);
        end
    end

    // A flag arriving in the tick cycle still counts for that cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            valley_seen_q <= 1'b0;
        end else if (!switching || cyc_tick) begin
            valley_seen_q <= 1'b0;
        end else if (s_valley) begin
            valley_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fault_count_q <= FAULT_MIN;
        end else if (!switching) begin
            fault_count_q <= FAULT_MIN;
        end else if (cyc_tick) begin
            if (valley_seen_q || s_valley) begin
                if (fault_count_q != FAULT_MAX) begin
                    fault_count_q <= fault_count_q + 4'h1;
                end
            end else if (fault_count_q != FAULT_MIN) begin
                fault_count_q <= fault_count_q - 4'h1;
            end
        end
    end

    // ==========================================================
    // Gate drive
    // ==========================================================
    always_comb begin
        hs_on_d = high_side_on_q;
        if (!switching || cyc_tick) begin
            hs_on_d = 1'b0;
        end else if (high_side_on_q) begin
            if (s_hs_limit && blank_cnt_q == BLANK_CYCLES) begin
                hs_on_d = 1'b0;
            end
        end else if (!hs_done_q && s_on_req && !s_valley) begin
            hs_on_d = 1'b1;
        end
    end

    // One turn-on per cycle; a request never served is skipped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hs_done_q <= 1'b0;
        end else if (!switching || cyc_tick) begin
            hs_done_q <= 1'b0;
        end else if (hs_on_d) begin
            hs_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blank_cnt_q <= '0;
        end else if (!high_side_on_q) begin
            blank_cnt_q <= '0;
        end else if (blank_cnt_q != BLANK_CYCLES) begin
            blank_cnt_q <= blank_cnt_q + BLANK_W'(1);
        end
    end

    // Diode emulation during the ramp keeps a pre-charged output
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ls_block_q <= 1'b0;
        end else if (state_q != ST_SOFT || cyc_tick) begin
            ls_block_q <= 1'b0;
        end else if (s_reverse) begin
            ls_block_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            high_side_on_q   <= 1'b0;
            low_side_on_q    <= 1'b0;
            stage_tristate_q <= 1'b1;
        end else begin
            high_side_on_q   <= hs_on_d;
            low_side_on_q    <= switching && !hs_on_d &&
                                !ls_block_q && !(state_q == ST_SOFT &&
                                                 s_reverse);
            stage_tristate_q <= !switching;
        end
    end

    // ==========================================================
    // Status
    // ==========================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ldo_enable_q        <= 1'b0;
            soft_start_active_q <= 1'b0;
            hiccup_active_q     <= 1'b0;
            thermal_shutdown_q  <= 1'b0;
        end else begin
            ldo_enable_q        <= s_en_supply;
            soft_start_active_q <= (state_q == ST_SOFT);
            hiccup_active_q     <= (state_q == ST_HICCUP);
            thermal_shutdown_q  <= (state_q == ST_THERMAL);
        end
    end

endmodule

// ==== verification/bphc_assertions.sv ====
`timescale 1ns/1ps
module bphc_assertions
    import bphc_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input wire logic             valley_limit_flag,
    input wire logic             high_side_limit_flag,
    input wire logic             over_temp_flag,
    input wire logic             high_side_on_q,
    input wire logic             stage_tristate_q,
    input wire logic [REF_W-1:0] reference_mv_q,
    input wire logic [3:0]       vout_setpoint_code_q,
    input wire logic [3:0]       fault_count_q,
    input wire logic             soft_start_active_q,
    input wire logic             hiccup_active_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_valley_hold: assert property (valley_limit_flag[*4] |->
        !$rose(high_side_on_q)) else $error("turn-on in valley limit");
    a_limit_cut: assert property ($rose(high_side_on_q) &&
        high_side_limit_flag |-> high_side_on_q[*8] ##[12:24] !high_side_on_q)
        else $error("limit cut timing");
    a_fault_step: assert property ($changed(fault_count_q) |->
        fault_count_q == 4'h0 || 5'(fault_count_q) - 5'($past(fault_count_q))
        inside {5'h01, 5'h1f}) else $error("fault count jump");
    a_fault_hiccup: assert property (fault_count_q == FAULT_MAX |->
        ##[1:3] stage_tristate_q && hiccup_active_q) else $error("no hiccup");
    a_hiccup_idle: assert property (hiccup_active_q[*2] |->
        stage_tristate_q && reference_mv_q == 12'h000) else $error("live");
    a_ramp_step: assert property (soft_start_active_q &&
        $changed(reference_mv_q) |-> reference_mv_q == 12'h000 ||
        reference_mv_q == $past(reference_mv_q) + 12'h001) else $error("ramp");
    a_heat_stop: assert property (over_temp_flag[*6] |->
        stage_tristate_q) else $error("switching while hot");
    a_strap_hold: assert property (soft_start_active_q |->
        $stable(vout_setpoint_code_q)) else $error("strap code moved");
    c_hiccup: cover property ($rose(hiccup_active_q));
    c_restart: cover property ($rose(soft_start_active_q));
    c_cut: cover property ($fell(high_side_on_q) &&
        $past(high_side_limit_flag));
endmodule
bind bphc_top bphc_assertions i_chk (.*);

// ==== verification/bphc_stage_model.sv ====
`timescale 1ns/1ps
module bphc_stage_model (
    // Switch state and fault selection
    input  wire logic high_side_on_q,
    input  wire logic low_side_on_q,
    input  wire logic short_mode,
    input  wire logic limit_mode,
    // Comparator and modulator outputs
    output wire logic valley_limit_flag,
    output wire logic high_side_limit_flag,
    output wire logic modulator_on_request
);
    // A shorted output keeps the valley current high while the low side is on
    assign valley_limit_flag    = short_mode && low_side_on_q;
    assign high_side_limit_flag = limit_mode && high_side_on_q;
    assign modulator_on_request = !high_side_on_q;
endmodule

// ==== verification/bphc_top_test.sv ====
`timescale 1ns/1ps
module bphc_top_test
    import bphc_pkg::*;
;
    logic        clk_sys = 1'b0, rst_n = 1'b0, reverse_current_flag = 1'b0;
    logic        enable_delay_input_supply = 1'b0, over_temp_flag = 1'b0;
    logic        enable_delay_input_deliver = 1'b0, short_mode = 1'b0;
    logic        limit_mode = 1'b0, high_side_on_q, low_side_on_q;
    logic        stage_tristate_q, ldo_enable_q, soft_start_active_q;
    logic        hiccup_active_q, thermal_shutdown_q, valley_limit_flag;
    logic        high_side_limit_flag, modulator_on_request;
    logic [1:0]  switching_rate_code_q, valley_limit_code_q;
    logic [1:0]  f_s = 2'h2, h_s = 2'h2, l_s = 2'h2, c_s = 2'h2;
    logic [3:0]  vout_setpoint_code_q, fault_count_q;
    logic [11:0] reference_mv_q;
    int          n_errors = 0, n_checks = 0, cyc = 0, n;
    wire switching_rate_select_above = f_s == 2'h1;
    wire switching_rate_select_below = f_s == 2'h0;
    wire vout_code_high_above = h_s == 2'h1;
    wire vout_code_high_below = h_s == 2'h0;
    wire vout_code_low_above = l_s == 2'h1;
    wire vout_code_low_below = l_s == 2'h0;
    wire valley_limit_select_above = c_s == 2'h1;
    wire valley_limit_select_below = c_s == 2'h0;
    bphc_top #(.SS_STEP_CYCLES(12)) i_dut (.*);
    bphc_stage_model i_stage (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    initial begin
        tick(20);
        rst_n = 1'b1;
        chk("reset", 12'h122, {3'h0, stage_tristate_q, switching_rate_code_q,
            vout_setpoint_code_q, valley_limit_code_q});
        enable_delay_input_supply = 1'b1;
        tick(6);
        chk("supply", 12'h003,
            {10'h0, ldo_enable_q, stage_tristate_q});
        for (int i = 0; i < 9; i++) begin
            h_s = 2'(18'h29850 >> (2 * i));
            l_s = 2'(18'h26244 >> (2 * i));
            f_s = 2'(i % 3);
            c_s = f_s;
            enable_delay_input_deliver = 1'b1;
            tick(8);
            {f_s, h_s} = 4'h0;
            tick(6);
            chk("rate", 12'((i + 1) % 3), 12'(switching_rate_code_q));
            chk("vout", 12'(i), 12'(vout_setpoint_code_q));
            chk("limit", 12'(i % 3), 12'(valley_limit_code_q));
            enable_delay_input_deliver = 1'b0;
            tick(4);
        end
        {f_s, h_s, l_s, c_s} = 8'haa;
        enable_delay_input_deliver = 1'b1;
        tick(6);
        for (n = 0; n < 9000 && reference_mv_q !== 12'h2bc; n++) tick(1);
        chk("ramp", 12'h001, {11'h0, n > 8380 && n < 8420});
        over_temp_flag = 1'b1;
        tick(8);
        chk("hot", 12'h003,
            {10'h0, thermal_shutdown_q, stage_tristate_q});
        over_temp_flag = 1'b0;
        short_mode = 1'b1;
        tick(8);
        chk("cooled", 12'h001, {11'h0, soft_start_active_q});
        for (n = 0; n < 9000 && hiccup_active_q !== 1'b1; n++) tick(1);
        chk("count", 12'h001, {11'h0, n > 6900 && n < 8100});
        short_mode = 1'b0;
        for (n = 0; n < 30000 && soft_start_active_q !== 1'b1; n++) tick(1);
        chk("wait", 12'h001, {11'h0, n > 25180 && n < 25220});
        short_mode = 1'b1;
        tick(2000);
        chk("burst", 12'h001, {11'h0, fault_count_q inside {[3:5]}});
        short_mode = 1'b0;
        limit_mode = 1'b1;
        tick(4000);
        chk("drained", 12'h000, {8'h0, fault_count_q});
        reverse_current_flag = 1'b1;
        tick(40);
        chk("prebias", 12'h000, {11'h0, low_side_on_q});
        give_verdict();
    end
endmodule
